// ==== ctu_pkg.sv ====
package ctu_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] CTU_ADDR_CURRENT = 5'h00;
	localparam logic [4:0] CTU_ADDR_EDGE_LOW = 5'h04;
	localparam logic [4:0] CTU_ADDR_EDGE_HIGH = 5'h08;
	localparam logic [4:0] CTU_ADDR_IRQ_STATUS = 5'h0c;
	localparam logic [4:0] CTU_ADDR_IRQ_CLEAR = 5'h10;
	localparam logic [4:0] CTU_ADDR_IRQ_ENABLE = 5'h14;
	localparam int CTU_ADDR_W = 5;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTU_RANGE_LSB = 0;
	localparam int CTU_TRIM_LSB = 2;
	localparam int CTU_SEEN_ONE_BIT = 0;
	localparam int CTU_SEEN_TWO_BIT = 1;
	localparam int CTU_SRC_ONE_LSB = 2;
	localparam int CTU_POL_ONE_BIT = 4;
	localparam int CTU_SRC_TWO_LSB = 5;
	localparam int CTU_POL_TWO_BIT = 7;
	localparam int CTU_TRIG_EN_BIT = 0;
	localparam int CTU_ORDER_EN_BIT = 2;
	localparam int CTU_DISCHARGE_BIT = 3;
	localparam int CTU_UNIT_EN_BIT = 7;
	localparam logic [7:0] CTU_HIGH_MASK = 8'h8d;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [7:0] CTU_REG_RESET = 8'h00;
	localparam logic [1:0] CTU_RANGE_LOWEST = 2'h0;
	localparam logic [5:0] CTU_TRIM_NEUTRAL = 6'h00;
	localparam logic [5:0] CTU_TRIM_MAX_DOWN = 6'h20;
	localparam logic [5:0] CTU_TRIM_MAX_UP = 6'h1f;
	localparam int CTU_TRIM_STEP_PCT = 2;
	localparam int CTU_IRQ_W = 3;
	localparam logic [1:0] CTU_RESP_OKAY = 2'h0;
	localparam logic [1:0] CTU_RESP_SLVERR = 2'h2;

	// edge source selection codes
	typedef enum logic [1:0] {
		CTU_SRC_PIN_ONE = 2'h0,
		CTU_SRC_PIN_TWO = 2'h1,
		CTU_SRC_EVT_ONE = 2'h2,
		CTU_SRC_EVT_TWO = 2'h3
	} ctu_src_t;
endpackage

// ==== ctu_edge_sync.sv ====
`timescale 1ns/1ps
module ctu_edge_sync
	import ctu_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] synced
);
	// two-stage chain; the first stage feeds only the second
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_synced;

	always_comb begin
		next_stage_one = raw;
		next_synced = stage_one;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage_one <= '0;
			synced <= '0;
		end else begin
			stage_one <= next_stage_one;
			synced <= next_synced;
		end
	end
endmodule

// ==== ctu_channel.sv ====
`timescale 1ns/1ps
module ctu_channel
	import ctu_pkg::*;
(
	input wire logic [3:0] sources,
	input wire logic [1:0] source_sel,
	input wire logic polarity,
	output logic active
);
	// level-sensitive: active while the chosen input equals the polarity level
	always_comb begin
		active = (sources[source_sel] == polarity);
	end
endmodule

// ==== ctu_top.sv ====
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module ctu_top
	import ctu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic edge_pin_one,
	input wire logic edge_pin_two,
	input wire logic capture_compare_event_one,
	input wire logic capture_compare_event_two,
	output logic current_source_on,
	output logic [1:0] current_range_sel,
	output logic [5:0] current_trim,
	output logic discharge_on,
	output logic adc_trigger,
	output logic irq
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] current_source_control;
	logic [7:0] edge_control_low;
	logic [7:0] edge_control_high;
	logic [CTU_IRQ_W-1:0] irq_status;
	logic [CTU_IRQ_W-1:0] irq_enable;
	logic [7:0] next_current_source_control;
	logic [7:0] next_edge_control_low;
	logic [7:0] next_edge_control_high;
	logic [CTU_IRQ_W-1:0] next_irq_status;
	logic [CTU_IRQ_W-1:0] next_irq_enable;

	// ----------------------------------------
	// bus state
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [CTU_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [CTU_ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic do_write;

	// ----------------------------------------
	// outputs and helpers
	// ----------------------------------------
	logic next_source_on;
	logic next_discharge;
	logic next_trigger;
	logic next_irq;
	logic trig_en_prev;
	logic next_trig_en_prev;
	logic [3:0] synced;
	logic chan_one_active;
	logic chan_two_active;
	logic chan_one_seen;
	logic chan_two_seen;
	logic unit_enable;
	logic edge_order_enable;
	logic adc_trigger_enable;
	logic discharge_enable;
	logic [7:0] read_byte;
	logic read_ok;

	function automatic logic addr_known(input logic [CTU_ADDR_W-1:0] a);
		addr_known = (a == CTU_ADDR_CURRENT) || (a == CTU_ADDR_EDGE_LOW) || (a == CTU_ADDR_EDGE_HIGH) ||
			(a == CTU_ADDR_IRQ_STATUS) || (a == CTU_ADDR_IRQ_CLEAR) || (a == CTU_ADDR_IRQ_ENABLE);
	endfunction

	assign chan_one_seen = edge_control_low[CTU_SEEN_ONE_BIT];
	assign chan_two_seen = edge_control_low[CTU_SEEN_TWO_BIT];
	assign unit_enable = edge_control_high[CTU_UNIT_EN_BIT];
	assign edge_order_enable = edge_control_high[CTU_ORDER_EN_BIT];
	assign adc_trigger_enable = edge_control_high[CTU_TRIG_EN_BIT];
	assign discharge_enable = edge_control_high[CTU_DISCHARGE_BIT];

	// ----------------------------------------
	// edge inputs
	// ----------------------------------------
	// all four sources are synchronised before selection so a source change never glitches a channel
	ctu_edge_sync #(.WIDTH(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw({capture_compare_event_two, capture_compare_event_one, edge_pin_two, edge_pin_one}),
		.synced(synced)
	);

	ctu_channel u_chan_one (
		.sources(synced),
		.source_sel(edge_control_low[CTU_SRC_ONE_LSB +: 2]),
		.polarity(edge_control_low[CTU_POL_ONE_BIT]),
		.active(chan_one_active)
	);

	ctu_channel u_chan_two (
		.sources(synced),
		.source_sel(edge_control_low[CTU_SRC_TWO_LSB +: 2]),
		.polarity(edge_control_low[CTU_POL_TWO_BIT]),
		.active(chan_two_active)
	);

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = 1'b0;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[CTU_ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			do_write = addr_known(aw_addr);
			next_bvalid = 1'b1;
			next_bresp = addr_known(aw_addr) ? CTU_RESP_OKAY : CTU_RESP_SLVERR;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		case (s_axi_araddr[CTU_ADDR_W-1:0])
			CTU_ADDR_CURRENT: read_byte = current_source_control;
			CTU_ADDR_EDGE_LOW: read_byte = edge_control_low;
			CTU_ADDR_EDGE_HIGH: read_byte = edge_control_high;
			CTU_ADDR_IRQ_STATUS: read_byte = {5'h00, irq_status};
			CTU_ADDR_IRQ_ENABLE: read_byte = {5'h00, irq_enable};
			default: read_byte = 8'h00;
		endcase
		read_ok = addr_known(s_axi_araddr[CTU_ADDR_W-1:0]);
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = {24'h000000, read_byte};
			next_rresp = read_ok ? CTU_RESP_OKAY : CTU_RESP_SLVERR;
		end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
			next_arready = 1'b1;
		end
	end

	// ----------------------------------------
	// control and status
	// ----------------------------------------
	always_comb begin
		next_current_source_control = current_source_control;
		next_edge_control_low = edge_control_low;
		next_edge_control_high = edge_control_high;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		// range and trim are stored as written; the analog side decodes them
		if (do_write && w_strb[0]) begin
			case (aw_addr)
				CTU_ADDR_CURRENT: next_current_source_control = w_data[7:0];
				CTU_ADDR_EDGE_LOW: next_edge_control_low = w_data[7:0];
				CTU_ADDR_EDGE_HIGH: next_edge_control_high = w_data[7:0] & CTU_HIGH_MASK;
				CTU_ADDR_IRQ_ENABLE: next_irq_enable = w_data[CTU_IRQ_W-1:0];
				CTU_ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~w_data[CTU_IRQ_W-1:0];
				default: next_irq_enable = irq_enable;
			endcase
		end
		// hardware set follows the write, so an event in the cleared cycle wins; the new
		// configuration takes effect next cycle, after which a matching level sets at once
		if (unit_enable) begin
			if (chan_one_active) begin
				next_edge_control_low[CTU_SEEN_ONE_BIT] = 1'b1;
			end
			if (chan_two_active && (!edge_order_enable || chan_one_seen)) begin
				next_edge_control_low[CTU_SEEN_TWO_BIT] = 1'b1;
			end
		end
		// interrupt events: each seen bit rising, and the trigger pulse
		if (next_edge_control_low[CTU_SEEN_ONE_BIT] && !chan_one_seen) begin
			next_irq_status[0] = 1'b1;
		end
		if (next_edge_control_low[CTU_SEEN_TWO_BIT] && !chan_two_seen) begin
			next_irq_status[1] = 1'b1;
		end
		if (next_trigger) begin
			next_irq_status[2] = 1'b1;
		end
	end

	always_comb begin
		// one seen bit exactly; both cleared in one write keeps the source off
		next_source_on = unit_enable && (chan_one_seen ^ chan_two_seen);
		next_discharge = discharge_enable;
		next_trig_en_prev = adc_trigger_enable && unit_enable;
		// one conversion per measurement: pulse when both edges are done and trigger is enabled
		next_trigger = adc_trigger_enable && unit_enable && chan_one_seen && chan_two_seen &&
			!trig_en_prev;
		next_irq = |(irq_status & irq_enable);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			current_source_control <= CTU_REG_RESET;
			edge_control_low <= CTU_REG_RESET;
			edge_control_high <= CTU_REG_RESET;
			irq_status <= '0;
			irq_enable <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CTU_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= CTU_RESP_OKAY;
			current_source_on <= 1'b0;
			current_range_sel <= CTU_RANGE_LOWEST;
			current_trim <= CTU_TRIM_NEUTRAL;
			discharge_on <= 1'b0;
			adc_trigger <= 1'b0;
			trig_en_prev <= 1'b0;
			irq <= 1'b0;
		end else begin
			current_source_control <= next_current_source_control;
			edge_control_low <= next_edge_control_low;
			edge_control_high <= next_edge_control_high;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			current_source_on <= next_source_on;
			current_range_sel <= current_source_control[CTU_RANGE_LSB +: 2];
			current_trim <= current_source_control[CTU_TRIM_LSB +: 6];
			discharge_on <= next_discharge;
			adc_trigger <= next_trigger;
			trig_en_prev <= next_trig_en_prev && chan_one_seen && chan_two_seen;
			irq <= next_irq;
		end
	end
endmodule

// ==== ctu_assertions.sv ====
`timescale 1ns/1ps
module ctu_assertions
	import ctu_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic current_source_on,
	input logic [1:0] current_range_sel,
	input logic [5:0] current_trim,
	input logic discharge_on,
	input logic adc_trigger,
	input logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_reset_clears: assert property (disable iff (1'b0) !aresetn |=> !current_source_on && !irq && !adc_trigger
		&& !discharge_on && current_trim == 6'h00 && current_range_sel == 2'h0) else $error("output set in reset");
	// both halves land in the held flags first, so the answer comes one edge later
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	// rearming needs a seen bit or an enable cleared by a write; a seen bit cleared and set again at once leaves one quiet cycle only
	chk_trig_single: assert property (adc_trigger |=> !adc_trigger [*2]) else $error("trigger too long");
	chk_trig_source_off: assert property (adc_trigger |-> !current_source_on) else $error("source on at trigger");
	chk_setting_by_write: assert property ($changed({current_range_sel, current_trim}) |->
		s_axi_bvalid || $past(s_axi_bvalid)) else $error("setting moved without write");
	cover property (adc_trigger);
	cover property ($rose(current_source_on));
	cover property (s_axi_bvalid && s_axi_bresp == CTU_RESP_SLVERR);
endmodule

bind ctu_top ctu_assertions i_ctu_assertions (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .current_source_on, .current_range_sel, .current_trim, .discharge_on,
	.adc_trigger, .irq);

// ==== ctu_partner.sv ====
`timescale 1ns/1ps
module ctu_partner (
	input logic aclk,
	input logic [3:0] level,
	output logic edge_pin_one = 1'b0,
	output logic edge_pin_two = 1'b0,
	output logic capture_compare_event_one = 1'b0,
	output logic capture_compare_event_two = 1'b0
);
	// levels held, not pulsed: the channels judge level only
	always @(posedge aclk) begin
		{capture_compare_event_two, capture_compare_event_one, edge_pin_two, edge_pin_one} <= level;
	end
endmodule

// ==== charge_time_edge_control_test.sv ====
`timescale 1ns/1ps
module charge_time_edge_control_test;
	import ctu_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [31:0] awa = 0, wda = 0, ara = 0, rdat, rd_val;
	logic [3:0] stb = 4'hf, lvl = 0;
	logic awv = 0, wdv = 0, brd = 0, arv = 0, rrd = 0, awr, wdr, bv, arr, rvl, irq, adc_trigger;
	logic edge_pin_one, edge_pin_two, capture_compare_event_one, capture_compare_event_two;
	logic current_source_on, discharge_on;
	logic [1:0] br, rr, current_range_sel, resp;
	logic [5:0] current_trim;
	int errors = 0, comparisons = 0, cyc = 0, trig_count = 0;
	always #50 aclk = ~aclk;
	// counts conversion start pulses on the pin itself
	always @(posedge aclk) if (adc_trigger === 1'b1) trig_count++;
	ctu_partner i_ctu_partner (.aclk, .level(lvl), .edge_pin_one, .edge_pin_two, .capture_compare_event_one,
		.capture_compare_event_two);
	ctu_top i_ctu_top (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wda), .s_axi_wstrb(stb), .s_axi_wvalid(wdv), .s_axi_wready(wdr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(rrd), .edge_pin_one,
		.edge_pin_two, .capture_compare_event_one, .capture_compare_event_two, .current_source_on,
		.current_range_sel, .current_trim, .discharge_on, .adc_trigger, .irq);
	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		awa <= {27'h0, a};
		wda <= {24'h0, d};
		awv <= 1;
		wdv <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wdr) wdv <= 0;
		end while (awv || wdv);
		do @(posedge aclk); while (!bv);
		brd <= 1;
		@(posedge aclk);
		resp = br;
		brd <= 0;
	endtask
	task automatic rd(input logic [4:0] a);
		ara <= {27'h0, a};
		arv <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		do @(posedge aclk); while (!rvl);
		rrd <= 1;
		@(posedge aclk);
		rd_val = rdat;
		resp = rr;
		rrd <= 0;
	endtask
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge aclk) if (cyc++ == 5000) begin
		errors++;
		conclude;
	end
	task automatic t_reset;
		for (int i = 0; i < 6; i++) begin
			rd(5'(4 * i));
			ck(rd_val, 0);
		end
		ck({current_source_on, discharge_on, irq, current_range_sel, current_trim}, 0);
	endtask
	task automatic t_current;
		logic [7:0] v[3] = '{8'h81, 8'h7e, 8'h00};
		for (int i = 0; i < 3; i++) begin
			wr(CTU_ADDR_CURRENT, v[i]);
			ck(current_range_sel, v[i][1:0]);
			ck(current_trim, v[i][7:2]);
			rd(CTU_ADDR_CURRENT);
			ck(rd_val, v[i]);
		end
	endtask
	task automatic t_edges;
		// configure while disabled, so the all-zero setup cannot set seen bits first
		wr(CTU_ADDR_EDGE_LOW, 8'hb0);
		wr(CTU_ADDR_EDGE_HIGH, 8'h81);
		lvl <= 4'h1;
		wt(5);
		ck(current_source_on, 0);
		wt(1);
		ck(current_source_on, 1);
		lvl <= 4'h3;
		wt(6);
		ck(current_source_on, 0);
		ck(irq, 0);
		rd(CTU_ADDR_IRQ_STATUS);
		ck(rd_val, 7);
		ck(trig_count, 1);
		wr(CTU_ADDR_IRQ_ENABLE, 8'h07);
		ck(irq, 1);
		wr(CTU_ADDR_EDGE_LOW, 8'hb0);
		rd(CTU_ADDR_EDGE_LOW);
		ck(rd_val, 8'hb3);
		lvl <= 4'h0;
		wt(5);
		wr(CTU_ADDR_EDGE_LOW, 8'hb0);
		ck(current_source_on, 0);
		wr(CTU_ADDR_IRQ_CLEAR, 8'h07);
		ck(irq, 0);
	endtask
	task automatic t_order;
		wr(CTU_ADDR_EDGE_HIGH, 8'h84);
		wr(CTU_ADDR_EDGE_LOW, 8'hf8);
		lvl <= 4'h8;
		wt(6);
		rd(CTU_ADDR_EDGE_LOW);
		ck(rd_val, 8'hf8);
		lvl <= 4'hc;
		wt(6);
		rd(CTU_ADDR_EDGE_LOW);
		ck(rd_val, 8'hfb);
		lvl <= 4'h0;
		wt(5);
		wr(CTU_ADDR_EDGE_LOW, 8'hb0);
	endtask
	task automatic t_soft;
		logic [7:0] v[4] = '{8'hb1, 8'hb3, 8'hb2, 8'hb0};
		wr(CTU_ADDR_EDGE_HIGH, 8'h80);
		for (int i = 0; i < 4; i++) begin
			wr(CTU_ADDR_EDGE_LOW, v[i]);
			ck(current_source_on, v[i][0] ^ v[i][1]);
		end
		wr(CTU_ADDR_EDGE_LOW, 8'ha0);
		rd(CTU_ADDR_EDGE_LOW);
		ck(rd_val, 8'ha1);
		wr(CTU_ADDR_EDGE_LOW, 8'hb1);
		wr(CTU_ADDR_EDGE_LOW, 8'hb0);
		wr(CTU_ADDR_IRQ_CLEAR, 8'h07);
	endtask
	task automatic t_disable;
		wr(CTU_ADDR_EDGE_HIGH, 8'h08);
		ck(discharge_on, 1);
		lvl <= 4'h3;
		wt(6);
		rd(CTU_ADDR_EDGE_LOW);
		ck(rd_val, 8'hb0);
		wr(CTU_ADDR_EDGE_LOW, 8'hb1);
		ck(current_source_on, 0);
		lvl <= 4'h0;
		wr(CTU_ADDR_EDGE_HIGH, 8'h00);
		ck(discharge_on, 0);
		wr(5'h18, 8'h55);
		ck(resp, CTU_RESP_SLVERR);
		rd(5'h18);
		ck(resp, CTU_RESP_SLVERR);
		ck(rd_val, 0);
		ck(trig_count, 1);
	endtask
	initial begin
		wt(4);
		aresetn <= 1;
		wt(1);
		t_reset;
		t_current;
		t_edges;
		t_order;
		t_soft;
		t_disable;
		conclude;
	end
endmodule
